//--- include/battery_mode_regs.svh
// register offsets, field positions, reset values and timing counts of the mode sequencer
`ifndef BATTERY_MODE_REGS_SVH
`define BATTERY_MODE_REGS_SVH

// ==================== register offsets
`define REG_CONTROL        5'h00
`define REG_STATUS         5'h01
`define REG_SEGMENT        5'h02
`define REG_SCRATCH_BASE   5'h08

// ==================== control fields
`define CTL_CONVERTER_RUN  0
`define CTL_COMPUTE_RUN    1
`define CTL_DISPLAY_ONLY   2
`define CTL_SLEEP          3
`define CTL_DIV_LSB        4
`define CTL_DIV_MSB        6
`define CTL_RESET_VALUE    8'h00
`define CTL_WRITE_MASK     8'h7F
// run and request bits lost on a wake, divider kept
`define CTL_WAKE_CLEAR     8'h0F

// ==================== status fields
`define STS_TIMER_WAKE     4
`define STS_BUTTON_WAKE    5
`define STS_COMPARATOR     6
`define STS_PLL_LOCKED     7

// ==================== timing
`define REF_CLK_HZ         20000000
`define XTAL_HZ            32768
`define XTAL_DIV           (`REF_CLK_HZ / `XTAL_HZ)
`define CPU_SLOW_SKIP      3'h7
`define RESET_TICKS_POWER  4100
`define RESET_TICKS_BATT   2
`define BLINK_TICKS        16384
`define UART_BATT_BAUD     300
`define EE2_BATT_BPS       8000
`define EE3_BATT_BPS       16000

`endif

//--- include/battery_mode_pkg.sv
// types of the power-mode and reset sequencer
package battery_mode_pkg;
    typedef enum logic [4:0] {
        FULL_POWER_STATE   = 5'h01,
        BATTERY_RUN_STATE  = 5'h02,
        DISPLAY_HOLD_STATE = 5'h04,
        SLEEP_STATE        = 5'h08,
        RESET_STATE        = 5'h10
    } mode_t;
endpackage

//--- logic/battery_mode_reset_sequencer.sv
// power-mode and reset sequencer with its control registers
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "battery_mode_regs.svh"

module battery_mode_reset_sequencer #(
    parameter int RESET_TICKS_POWER = `RESET_TICKS_POWER,
    parameter int BLINK_TICKS       = `BLINK_TICKS
) (
    // clock and chip reset
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RESET,
    // pins and analog status
    input  wire logic       I_RESET_PIN,
    input  wire logic       I_SUPPLY_COMPARATOR,
    input  wire logic       I_PLL_LOCKED,
    input  wire logic       I_SUPPLY_HEADROOM_OK,
    input  wire logic       I_TIMER_EXPIRED,
    input  wire logic       I_BUTTON_INPUT,
    // register port
    input  wire logic [4:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    // cpu control
    output logic            O_CPU_RESET,
    output logic            O_CPU_CLK_FROM_PLL,
    output logic            O_CPU_CLK_EN,
    output logic      [2:0] O_CPU_CLOCK_DIVIDER,
    output logic            O_RESUME,
    // metering control
    output logic            O_CONVERTER_RUN,
    output logic            O_COMPUTE_RUN,
    output logic            O_CE_PC_CLEAR,
    output logic            O_FIR_RUN,
    output logic            O_ANALOG_EN,
    // peripherals and display
    output logic            O_PERIPH_EN,
    output logic            O_PERIPH_SLOW,
    output logic            O_DISPLAY_EN,
    output logic            O_DISPLAY_FROM_PATTERN,
    output logic      [3:0] O_BLINK_SEGMENTS,
    // mode and events
    output logic      [4:0] O_MODE,
    output logic            O_POWER_RETURN_EVENT
);

    localparam int TICK_DIV = `XTAL_DIV;

    // ==================== input synchronisers
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [5:0] prev_q;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            prev_q  <= 6'h00;
        end else begin
            sync1_q <= {I_BUTTON_INPUT, I_TIMER_EXPIRED, I_SUPPLY_HEADROOM_OK,
                        I_PLL_LOCKED, I_SUPPLY_COMPARATOR, I_RESET_PIN};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end
    logic pin_s, supply_s, pll_s, headroom_s, timer_rise, button_rise, pll_fall;
    assign pin_s       = sync2_q[0];
    assign supply_s    = sync2_q[1];
    assign pll_s       = sync2_q[2];
    assign headroom_s  = sync2_q[3];
    assign timer_rise  = sync2_q[4] & ~prev_q[4];
    assign button_rise = sync2_q[5] & ~prev_q[5];
    assign pll_fall    = prev_q[2] & ~pll_s;

    // ==================== crystal tick and slow cpu clock
    logic [9:0]  div_q, div_d;
    logic [2:0]  phase_q, phase_d;
    logic [13:0] blink_q, blink_d;
    logic        blink_on_q, blink_on_d;
    logic        tick;
    assign tick = (div_q == 10'(TICK_DIV - 1));
    always_comb begin
        div_d      = tick ? 10'h000 : div_q + 10'h001;
        phase_d    = tick ? phase_q + 3'h1 : phase_q;
        blink_d    = blink_q;
        blink_on_d = blink_on_q;
        if (tick) begin
            blink_d = (blink_q == 14'(BLINK_TICKS - 1)) ? 14'h0000 : blink_q + 14'h0001;
            if (blink_q == 14'(BLINK_TICKS - 1)) begin
                blink_on_d = ~blink_on_q;
            end
        end
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            div_q      <= 10'h000;
            phase_q    <= 3'h0;
            blink_q    <= 14'h0000;
            blink_on_q <= 1'b0;
        end else begin
            div_q      <= div_d;
            phase_q    <= phase_d;
            blink_q    <= blink_d;
            blink_on_q <= blink_on_d;
        end
    end

    // ==================== mode state machine
    battery_mode_pkg::mode_t state_q, state_d;
    logic [12:0] rst_cnt_q, rst_cnt_d;
    logic        exit_wake, exit_timer, exit_button, enter_full_from_batt, resume_d;
    logic [7:0]  ctrl_q;

    always_comb begin
        state_d              = state_q;
        rst_cnt_d            = rst_cnt_q;
        exit_wake            = 1'b0;
        exit_timer           = 1'b0;
        exit_button          = 1'b0;
        enter_full_from_batt = 1'b0;
        resume_d             = 1'b0;
        if (pin_s) begin
            state_d   = battery_mode_pkg::RESET_STATE;
            rst_cnt_d = 13'h0000;
        end else begin
            case (state_q)
                battery_mode_pkg::RESET_STATE: begin
                    if (tick) begin
                        rst_cnt_d = rst_cnt_q + 13'h0001;
                    end
                    if (supply_s) begin
                        if (rst_cnt_q >= 13'(RESET_TICKS_POWER) && pll_s) begin
                            state_d  = battery_mode_pkg::FULL_POWER_STATE;
                            resume_d = 1'b1;
                        end
                    end else if (rst_cnt_q >= 13'(`RESET_TICKS_BATT)) begin
                        state_d  = battery_mode_pkg::BATTERY_RUN_STATE;
                        resume_d = 1'b1;
                    end
                end
                battery_mode_pkg::FULL_POWER_STATE: begin
                    if (!supply_s) begin
                        state_d = headroom_s ? battery_mode_pkg::BATTERY_RUN_STATE
                                             : battery_mode_pkg::SLEEP_STATE;
                    end
                end
                battery_mode_pkg::BATTERY_RUN_STATE: begin
                    if (supply_s && pll_s) begin
                        state_d              = battery_mode_pkg::FULL_POWER_STATE;
                        enter_full_from_batt = 1'b1;
                    end else if (!headroom_s) begin
                        state_d = battery_mode_pkg::SLEEP_STATE;
                    end else if (ctrl_q[`CTL_SLEEP]) begin
                        state_d = battery_mode_pkg::SLEEP_STATE;
                    end else if (ctrl_q[`CTL_DISPLAY_ONLY]) begin
                        state_d = battery_mode_pkg::DISPLAY_HOLD_STATE;
                    end
                end
                battery_mode_pkg::DISPLAY_HOLD_STATE,
                battery_mode_pkg::SLEEP_STATE: begin
                    // headroom recovery is no exit cause
                    if (supply_s && pll_s) begin
                        state_d   = battery_mode_pkg::FULL_POWER_STATE;
                        exit_wake = 1'b1;
                    end else if (timer_rise || button_rise) begin
                        state_d     = battery_mode_pkg::BATTERY_RUN_STATE;
                        exit_wake   = 1'b1;
                        exit_timer  = timer_rise;
                        exit_button = button_rise;
                    end
                end
                default: begin
                    state_d = battery_mode_pkg::RESET_STATE;
                end
            endcase
        end
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            state_q   <= battery_mode_pkg::RESET_STATE;
            rst_cnt_q <= 13'h0000;
        end else begin
            state_q   <= state_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // ==================== registers
    logic [1:0] flag_q, flag_d;
    logic [7:0] seg_q, seg_d, ctrl_d, rdata_d;
    logic [7:0] scratch_q [8];
    logic [7:0] scratch_d [8];
    logic       wr_ctrl, wr_sts;
    assign wr_ctrl = I_WR && (I_ADDR == `REG_CONTROL);
    assign wr_sts  = I_WR && (I_ADDR == `REG_STATUS);

    always_comb begin
        ctrl_d    = ctrl_q;
        seg_d     = seg_q;
        flag_d    = flag_q;
        scratch_d = scratch_q;
        if (wr_ctrl) begin
            ctrl_d = I_WDATA & `CTL_WRITE_MASK;
        end
        if (I_WR && I_ADDR == `REG_SEGMENT) begin
            seg_d = I_WDATA;
        end
        if (I_WR && I_ADDR[4:3] == 2'(`REG_SCRATCH_BASE >> 3)) begin
            scratch_d[I_ADDR[2:0]] = I_WDATA;
        end
        // write one to clear; a same-cycle wake event wins
        if (wr_sts) begin
            flag_d = flag_q & ~I_WDATA[`STS_BUTTON_WAKE:`STS_TIMER_WAKE];
        end
        flag_d = flag_d | {exit_button, exit_timer};
        if (exit_wake) begin
            ctrl_d = ctrl_q & ~`CTL_WAKE_CLEAR;
        end
        if (pin_s) begin
            ctrl_d = `CTL_RESET_VALUE;
            seg_d  = 8'h00;
            flag_d = 2'h0;
            for (int i = 0; i < 8; i++) begin
                scratch_d[i] = 8'h00;
            end
        end
        rdata_d = 8'h00;
        if (I_RD) begin
            case (I_ADDR)
                `REG_CONTROL: rdata_d = ctrl_q;
                `REG_STATUS:  rdata_d = {pll_s, supply_s, flag_q, 4'(state_q)};
                `REG_SEGMENT: rdata_d = seg_q;
                default: begin
                    if (I_ADDR[4:3] == 2'(`REG_SCRATCH_BASE >> 3)) begin
                        rdata_d = scratch_q[I_ADDR[2:0]];
                    end
                end
            endcase
        end
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            ctrl_q  <= `CTL_RESET_VALUE;
            seg_q   <= 8'h00;
            flag_q  <= 2'h0;
            O_RDATA <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                scratch_q[i] <= 8'h00;
            end
        end else begin
            ctrl_q    <= ctrl_d;
            seg_q     <= seg_d;
            flag_q    <= flag_d;
            O_RDATA   <= rdata_d;
            scratch_q <= scratch_d;
        end
    end

    // ==================== registered outputs
    logic full, batt, hold;
    assign full = (state_q == battery_mode_pkg::FULL_POWER_STATE);
    assign batt = (state_q == battery_mode_pkg::BATTERY_RUN_STATE);
    assign hold = (state_q == battery_mode_pkg::DISPLAY_HOLD_STATE);
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            O_CPU_RESET            <= 1'b1;
            O_CPU_CLK_FROM_PLL     <= 1'b0;
            O_CPU_CLK_EN           <= 1'b0;
            O_CPU_CLOCK_DIVIDER    <= 3'h0;
            O_RESUME               <= 1'b0;
            O_CONVERTER_RUN        <= 1'b0;
            O_COMPUTE_RUN          <= 1'b0;
            O_CE_PC_CLEAR          <= 1'b0;
            O_FIR_RUN              <= 1'b0;
            O_ANALOG_EN            <= 1'b0;
            O_PERIPH_EN            <= 1'b0;
            O_PERIPH_SLOW          <= 1'b0;
            O_DISPLAY_EN           <= 1'b0;
            O_DISPLAY_FROM_PATTERN <= 1'b0;
            O_BLINK_SEGMENTS       <= 4'h0;
            O_MODE                 <= 5'h10;
            O_POWER_RETURN_EVENT   <= 1'b0;
        end else begin
            O_CPU_RESET        <= !(full || batt);
            O_CPU_CLK_FROM_PLL <= full;
            // slow clock drops one crystal tick in eight; jitter is accepted
            O_CPU_CLK_EN       <= full || (batt && tick && phase_q != `CPU_SLOW_SKIP);
            if (full) begin
                O_CPU_CLOCK_DIVIDER <= ctrl_q[`CTL_DIV_MSB:`CTL_DIV_LSB];
            end
            O_RESUME               <= resume_d;
            O_CONVERTER_RUN        <= full && pll_s && ctrl_q[`CTL_CONVERTER_RUN];
            O_COMPUTE_RUN          <= full && pll_s && ctrl_q[`CTL_COMPUTE_RUN];
            O_CE_PC_CLEAR          <= pll_fall;
            O_FIR_RUN              <= full && pll_s;
            O_ANALOG_EN            <= full;
            O_PERIPH_EN            <= full || batt;
            O_PERIPH_SLOW          <= batt;
            O_DISPLAY_EN           <= full || batt || hold;
            O_DISPLAY_FROM_PATTERN <= hold;
            O_BLINK_SEGMENTS       <= hold ? (seg_q[3:0] & ~(seg_q[7:4] & {4{blink_on_q}}))
                                           : 4'h0;
            O_MODE                 <= state_q;
            O_POWER_RETURN_EVENT   <= enter_full_from_batt;
        end
    end

    // ==================== assertions
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);

    sequence batt_no_headroom;
        batt && !pin_s && !(supply_s && pll_s) && !headroom_s;
    endsequence
    sequence hold_wake;
        hold && !pin_s && !(supply_s && pll_s) && (timer_rise || button_rise);
    endsequence

    AST_SLOW_SKIP: assert property (batt && tick && phase_q == `CPU_SLOW_SKIP |=> !O_CPU_CLK_EN)
        else $error("slow cpu clock not skipped");
    AST_DIV_FROZEN: assert property (batt && $past(batt) |=> $stable(O_CPU_CLOCK_DIVIDER))
        else $error("divider changed in battery run");
    AST_HEADROOM_SLEEP: assert property (batt_no_headroom |=> state_q == battery_mode_pkg::SLEEP_STATE)
        else $error("no sleep on lost headroom");
    AST_PLL_GATE: assert property (!pll_s |=> !O_CONVERTER_RUN && !O_COMPUTE_RUN)
        else $error("run bits not forced off");
    AST_PC_CLEAR: assert property (pll_fall |=> O_CE_PC_CLEAR)
        else $error("engine pc not cleared");
    AST_HOLD_CPU_OFF: assert property (hold |=> O_CPU_RESET ##1 O_CPU_RESET || !hold)
        else $error("cpu running in display hold");
    AST_HOLD_STAY: assert property (hold && !pin_s && !(supply_s && pll_s) && !timer_rise
                                    && !button_rise |=> hold)
        else $error("display hold left without cause");
    AST_WAKE_FLAG: assert property (hold_wake and timer_rise |=> flag_q[0] && batt)
        else $error("timer wake not flagged");
    AST_PIN_PRIORITY: assert property (pin_s |=> state_q == battery_mode_pkg::RESET_STATE
                                       && ctrl_q == `CTL_RESET_VALUE)
        else $error("reset pin did not win");
    AST_BATT_RESET_TIME: assert property ($rose(O_RESUME) && !supply_s |->
                                          $past(rst_cnt_q) >= 13'(`RESET_TICKS_BATT))
        else $error("battery reset released early");
    AST_FULL_EVENT: assert property (batt && supply_s && pll_s && !pin_s |=>
                                     full && O_POWER_RETURN_EVENT)
        else $error("power return event missing");

endmodule // battery_mode_reset_sequencer
`default_nettype wire

//--- sim/supply_status_model.sv
// supply comparator, pll lock and regulator headroom model facing the sequencer
`timescale 1ns/1ns
`default_nettype none
// ==========
// model
module supply_status_model #(
    parameter int LOCK_CYCLES = 100
) (
    // bench control
    input  wire logic i_clk,
    input  wire logic i_mains_on,
    input  wire logic i_headroom,
    // status lines
    output logic      o_supply,
    output logic      o_pll_locked,
    output logic      o_headroom_ok
);
    int lock_cnt = 0;
    // lock is lost with the mains at once but regained only after a settling time
    always @(posedge i_clk) begin
        lock_cnt <= i_mains_on ? lock_cnt + 1 : 0;
    end
    assign o_supply      = i_mains_on;
    assign o_pll_locked  = i_mains_on && (lock_cnt >= LOCK_CYCLES);
    assign o_headroom_ok = i_headroom;
endmodule // supply_status_model
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench of the power-mode and reset sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ==========
    // constants and signals
    localparam int TICK = 610;
    localparam int RT   = 3;
    localparam logic [4:0] FULL = battery_mode_pkg::FULL_POWER_STATE;
    localparam logic [4:0] BATT = battery_mode_pkg::BATTERY_RUN_STATE;
    localparam logic [4:0] HOLD = battery_mode_pkg::DISPLAY_HOLD_STATE;
    localparam logic [4:0] SLP  = battery_mode_pkg::SLEEP_STATE;
    localparam logic [4:0] RST  = battery_mode_pkg::RESET_STATE;
    logic       clk, rst, pin, mains, head, tmr, btn, wr, rd;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       cpu_rst, from_pll, cen, resume, conv, comp, pc_clr, fir, analog;
    logic       periph, slow, disp, pat, evt, supply, pll, hok;
    logic [2:0] div;
    logic [3:0] blink;
    logic [4:0] mode;
    int         bad_count = 0;
    int         num_checks = 0;
    int         cyc = 0;
    int         waited, k, j;
    int         n_cen = 0, n_evt = 0, n_clr = 0, n_res = 0;

    supply_status_model #(.LOCK_CYCLES(100)) model (
        .i_clk(clk), .i_mains_on(mains), .i_headroom(head),
        .o_supply(supply), .o_pll_locked(pll), .o_headroom_ok(hok)
    );

    battery_mode_reset_sequencer #(.RESET_TICKS_POWER(RT), .BLINK_TICKS(2)) uut (
        .I_REF_CLK(clk), .I_RESET(rst), .I_RESET_PIN(pin), .I_SUPPLY_COMPARATOR(supply),
        .I_PLL_LOCKED(pll), .I_SUPPLY_HEADROOM_OK(hok), .I_TIMER_EXPIRED(tmr),
        .I_BUTTON_INPUT(btn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .O_CPU_RESET(cpu_rst), .O_CPU_CLK_FROM_PLL(from_pll),
        .O_CPU_CLK_EN(cen), .O_CPU_CLOCK_DIVIDER(div), .O_RESUME(resume),
        .O_CONVERTER_RUN(conv), .O_COMPUTE_RUN(comp), .O_CE_PC_CLEAR(pc_clr),
        .O_FIR_RUN(fir), .O_ANALOG_EN(analog), .O_PERIPH_EN(periph), .O_PERIPH_SLOW(slow),
        .O_DISPLAY_EN(disp), .O_DISPLAY_FROM_PATTERN(pat), .O_BLINK_SEGMENTS(blink),
        .O_MODE(mode), .O_POWER_RETURN_EVENT(evt)
    );

    // ==========
    // clock, pulse tallies and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cen === 1'b1) n_cen <= n_cen + 1;
        if (evt === 1'b1) n_evt <= n_evt + 1;
        if (pc_clr === 1'b1) n_clr <= n_clr + 1;
        if (resume === 1'b1) n_res <= n_res + 1;
        if (cyc == 40000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ==========
    // tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    task automatic wait_mode(input logic [4:0] m, input int lim);
        waited = 0;
        while (mode !== m && waited < lim) begin
            @(negedge clk);
            waited++;
        end
        chk({3'h0, mode}, {3'h0, m});
    endtask
    task automatic power(input logic on);
        @(posedge clk);
        mains <= on;
    endtask
    task automatic pulse(input logic which);
        @(posedge clk);
        if (which) btn <= 1'b1;
        else tmr <= 1'b1;
        repeat (4) @(posedge clk);
        btn <= 1'b0;
        tmr <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========
    // scenarios
    initial begin
        rst = 1'b1; pin = 1'b0; mains = 1'b1; head = 1'b1; tmr = 1'b0; btn = 1'b0;
        addr = 5'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wait_mode(FULL, 5 * TICK);
        chk({7'h0, waited > (RT - 1) * TICK && waited <= (RT + 1) * TICK}, 8'h01);
        repeat (3) @(negedge clk);
        chk({6'h0, n_res == 1, from_pll}, 8'h03);
        chk({3'h0, fir, analog, periph, slow, cen}, 8'h1D);
        wr_reg(5'h00, 8'h53);
        rd_reg(5'h00, 8'h53);
        chk({3'h0, conv, comp, div}, 8'h1D);
        for (int i = 0; i < 8; i++) wr_reg(5'(8 + i), 8'hA0 + 8'(i));
        rd_reg(5'h1F, 8'h00);
        rd_reg(5'h01, 8'hC1);
        // mains lost with headroom: battery run, metering off
        power(1'b0);
        wait_mode(BATT, 200);
        repeat (3) @(negedge clk);
        chk(8'(n_clr), 8'h01);
        chk({6'h0, conv, comp}, 8'h00);
        chk({3'h0, fir, analog, periph, slow, from_pll}, 8'h06);
        k = n_cen;
        repeat (8 * TICK) @(negedge clk);
        chk(8'(n_cen - k), 8'h07);
        rd_reg(5'h00, 8'h53);
        power(1'b1);
        wait_mode(FULL, 400);
        repeat (3) @(negedge clk);
        chk(8'(n_evt), 8'h01);
        rd_reg(5'h00, 8'h53);
        // firmware sleep, divider write ignored, timer wake
        power(1'b0);
        wait_mode(BATT, 200);
        wr_reg(5'h00, 8'h28);
        wait_mode(SLP, 50);
        chk({3'h0, cpu_rst, periph, div}, 8'h15);
        chk({7'h0, disp}, 8'h00);
        pulse(1'b0);
        wait_mode(BATT, 50);
        rd_reg(5'h01, 8'h12);
        rd_reg(5'h00, 8'h20);
        rd_reg(5'h0B, 8'hA3);
        wr_reg(5'h01, 8'h10);
        rd_reg(5'h01, 8'h02);
        // display hold with blinking segment, headroom loss ignored, button wake
        wr_reg(5'h02, 8'h35);
        wr_reg(5'h00, 8'h24);
        wait_mode(HOLD, 50);
        chk({5'h0, disp, pat, cpu_rst}, 8'h07);
        @(posedge clk);
        head <= 1'b0;
        k = 0;
        j = 0;
        repeat (4 * TICK) begin
            @(negedge clk);
            if (blink === 4'h5) k++;
            if (blink === 4'h4) j++;
        end
        chk({6'h0, k > 0, j > 0}, 8'h03);
        chk({3'h0, mode}, {3'h0, HOLD});
        @(posedge clk);
        head <= 1'b1;
        pulse(1'b1);
        wait_mode(BATT, 50);
        rd_reg(5'h01, 8'h22);
        wr_reg(5'h01, 8'h20);
        // headroom loss forces sleep that holds after recovery
        @(posedge clk);
        head <= 1'b0;
        wait_mode(SLP, 50);
        @(posedge clk);
        head <= 1'b1;
        repeat (200) @(negedge clk);
        chk({3'h0, mode}, {3'h0, SLP});
        power(1'b1);
        repeat (20) @(negedge clk);
        chk({7'h0, cpu_rst}, 8'h01);
        wait_mode(FULL, 400);
        rd_reg(5'h01, 8'hC1);
        // reset pin: defaults, writes lost, short unpowered release
        @(posedge clk);
        pin <= 1'b1;
        repeat (10) @(negedge clk);
        chk({2'h0, cpu_rst, mode}, {3'h1, RST});
        wr_reg(5'h00, 8'h03);
        rd_reg(5'h00, 8'h00);
        rd_reg(5'h08, 8'h00);
        power(1'b0);
        @(posedge clk);
        pin <= 1'b0;
        wait_mode(BATT, 4 * TICK);
        chk({7'h0, waited > TICK && waited <= 3 * TICK}, 8'h01);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
